/* include/cpp_defines.svh */
// Constants for the coprocessor acknowledge-stretch glue.
// Assumes one system clock; every time is kept in picoseconds.
`ifndef CPP_DEFINES_SVH
`define CPP_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CPP_CLK_PERIOD_PS 40000
`define CPP_ACK_MIN_PS 60000
`define CPP_HOST_ACK_MIN_PS 45500
`define CPP_ACK_MIN_CYC ((`CPP_ACK_MIN_PS + `CPP_CLK_PERIOD_PS - 1) / `CPP_CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Coprocessor clock divider
// ----------------------------------------------------------------
`define CPP_SRC_FREQ_MHZ 30
`define CPP_COP_FREQ_MHZ 10
`define CPP_DIV_RATIO (`CPP_SRC_FREQ_MHZ / `CPP_COP_FREQ_MHZ)
`define CPP_DIV_HIGH_CYC 1
`define CPP_DIV_W 2
`define CPP_CNT_W 3

// ----------------------------------------------------------------
// Reset value and mode-pin level
// ----------------------------------------------------------------
`define CPP_FLOP_RESET 1'b1
`define CPP_CLOCK_MODE_LEVEL 1'b1

`endif

/* include/cpp_pkg.sv */
// Types for the coprocessor acknowledge-stretch glue.
// Assumes cpp_defines.svh is on the include path.
`include "cpp_defines.svh"

package cpp_pkg;

  // ----------------------------------------------------------------
  // Signal groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack_n;
    logic phase2_start;
  } cpp_host_in_t;

  typedef struct packed {
    logic busy_n;
    logic error_n;
    logic operand_xfer_request;
  } cpp_cop_status_t;

  // ----------------------------------------------------------------
  // Stretch state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CPP_IDLE    = 3'h1,
    CPP_ARMED   = 3'h2,
    CPP_STRETCH = 3'h4
  } cpp_ack_state_t;

  typedef struct packed {
    cpp_ack_state_t st;
    logic flop;
    logic [`CPP_CNT_W-1:0] held;
  } cpp_stretch_t;

  typedef struct packed {
    logic [`CPP_DIV_W-1:0] phase;
    logic clk_out;
  } cpp_div_t;

endpackage

/* hdl/cpp_clk_div3.sv */
// Divide-by-three clock generator for the coprocessor.
// Assumes src_tick pulses once per source-clock period.
`include "cpp_defines.svh"

module cpp_clk_div3
  import cpp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic src_tick,
  output logic coproc_clk
);

  cpp_div_t state_q;
  cpp_div_t state_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    if (src_tick)
    begin
      if (state_q.phase == `CPP_DIV_W'(`CPP_DIV_RATIO - 1))
      begin
        state_d.phase = '0;
      end
      else
      begin
        state_d.phase = state_q.phase + `CPP_DIV_W'(1);
      end
      // High one source period of three: one-third duty
      state_d.clk_out = (state_d.phase < `CPP_DIV_W'(`CPP_DIV_HIGH_CYC));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign coproc_clk = state_q.clk_out;

endmodule

/* hdl/cpp_ack_glue.sv */
// Glue between a host processor and a slower numeric coprocessor.
// Assumes all pins are synchronous to clk_sys; host clock falling
// edges that open phase 2 arrive as one-cycle strobes.
`include "cpp_defines.svh"

// Operation
// - Reset presets stretch flop, output high.
// - Stretched ack is host ack AND flop.
// - Phase-2 edge of send state captures low.
// - Phase-2 edge of first command captures high.
// - Stretched ack meets coprocessor minimum width, except a one-cycle host pulse: split if it ends before phase 2, short if it ends at the phase-2 edge.
// - Coprocessor clock: thirty divided by three.
// - Busy and error pass straight through.
// - Transfer request passes straight through.
module cpp_ack_glue
  import cpp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic host_operand_ack_n,
  input wire logic host_phase2_start,
  input wire logic ext_freq_tick,
  input wire logic coproc_busy_n,
  input wire logic coproc_error_n,
  input wire logic operand_xfer_request,
  output logic stretched_operand_ack_n,
  output logic host_busy_n,
  output logic host_error_n,
  output logic host_operand_xfer_request,
  output logic coproc_clk,
  output logic coproc_clock_mode_select
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [`CPP_CNT_W-1:0] ACK_MIN = `CPP_CNT_W'(`CPP_ACK_MIN_CYC);

  // Width already served once the gate has been low this long
  function automatic logic width_met(input logic [`CPP_CNT_W-1:0] held);
    width_met = (held >= ACK_MIN);
  endfunction

  function automatic logic [`CPP_CNT_W-1:0] held_inc(input logic [`CPP_CNT_W-1:0] held);
    if (held == {`CPP_CNT_W{1'b1}})
    begin
      held_inc = held;
    end
    else
    begin
      held_inc = held + `CPP_CNT_W'(1);
    end
  endfunction

  cpp_host_in_t host_in;
  cpp_cop_status_t cop_in;
  cpp_stretch_t state_q;
  cpp_stretch_t state_d;
  logic gate_low;

  assign host_in.ack_n = host_operand_ack_n;
  assign host_in.phase2_start = host_phase2_start;
  assign cop_in.busy_n = coproc_busy_n;
  assign cop_in.error_n = coproc_error_n;
  assign cop_in.operand_xfer_request = operand_xfer_request;

  // ----------------------------------------------------------------
  // Stretched acknowledge gate
  // ----------------------------------------------------------------
  // Pure gate: host edge reaches the coprocessor with no clock delay
  assign gate_low = ~(host_in.ack_n & state_q.flop);
  assign stretched_operand_ack_n = host_in.ack_n & state_q.flop;

  // ----------------------------------------------------------------
  // Phase-2 edge decode
  // ----------------------------------------------------------------
  logic min_served;
  logic capture_low;
  logic capture_high;

  // Count-based guard: the host pulse alone may fall short
  assign min_served = width_met(state_q.held);
  // Low at the edge keeps the gate closed one more host period
  assign capture_low = host_in.phase2_start & ~host_in.ack_n;
  // High at the edge opens it, but never before the minimum
  assign capture_high = host_in.phase2_start & host_in.ack_n & min_served;

  // ----------------------------------------------------------------
  // Stretch flop and sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    if (gate_low)
    begin
      state_d.held = held_inc(state_q.held);
    end
    else
    begin
      state_d.held = '0;
    end
    unique case (state_q.st)
      CPP_IDLE:
      begin
        state_d.flop = `CPP_FLOP_RESET;
        if (!host_in.ack_n)
        begin
          state_d.st = CPP_ARMED;
        end
        // Acknowledge low already at the phase-2 edge
        if (capture_low)
        begin
          state_d.flop = 1'b0;
          state_d.st = CPP_STRETCH;
        end
      end
      CPP_ARMED:
      begin
        if (host_in.phase2_start)
        begin
          state_d.flop = host_in.ack_n;
          state_d.st = host_in.ack_n ? CPP_IDLE : CPP_STRETCH;
        end
        else if (host_in.ack_n)
        begin
          // Host pulse ended before any phase-2 edge: too short
          // to stretch by the flop, so hold the gate by count.
          // Limitation: the gate opens for one cycle before the
          // flop closes it again, so such a pulse arrives split;
          // a host that keeps its ack across phase 2 never sees this.
          if (!min_served)
          begin
            state_d.flop = 1'b0;
            state_d.st = CPP_STRETCH;
          end
          else
          begin
            state_d.st = CPP_IDLE;
          end
        end
      end
      CPP_STRETCH:
      begin
        // Release only on a phase-2 edge with the host ack high,
        // and never before the coprocessor minimum width
        if (capture_high)
        begin
          state_d.flop = 1'b1;
          state_d.st = CPP_IDLE;
        end
        else if (host_in.phase2_start)
        begin
          state_d.flop = host_in.ack_n & min_served;
        end
        if (!state_d.flop)
        begin
          state_d.st = CPP_STRETCH;
        end
        else
        begin
          state_d.st = CPP_IDLE;
        end
      end
      default:
      begin
        state_d.st = CPP_IDLE;
        state_d.flop = `CPP_FLOP_RESET;
      end
    endcase
  end

  // Preset, so the gate follows the host ack straight out of reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q.st <= CPP_IDLE;
      state_q.flop <= `CPP_FLOP_RESET;
      state_q.held <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Status and request paths
  // ----------------------------------------------------------------
  // Slow-to-fast direction already meets timing, so no retiming
  localparam int PASS_W = $bits(cpp_cop_status_t);

  logic [PASS_W-1:0] pass_in;
  logic [PASS_W-1:0] pass_out;
  cpp_cop_status_t pass_view;

  assign pass_in = cop_in;

  // One bare wire per line: no gate, no flop, no added delay
  for (genvar g = 0; g < PASS_W; g++)
  begin : g_pass
    assign pass_out[g] = pass_in[g];
  end

  assign pass_view = pass_out;
  assign host_busy_n = pass_view.busy_n;
  assign host_error_n = pass_view.error_n;
  assign host_operand_xfer_request = pass_view.operand_xfer_request;

  // ----------------------------------------------------------------
  // Coprocessor clock
  // ----------------------------------------------------------------
  cpp_clk_div3 u_div
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .src_tick(ext_freq_tick),
    .coproc_clk(coproc_clk)
  );

  // Dedicated clock driver in use, so the mode pin stays high
  assign coproc_clock_mode_select = `CPP_CLOCK_MODE_LEVEL;

endmodule

/* tb/cpp_cop_model.sv */
// Coprocessor stand-in: drives status lines, watches clock mode.
// Assumes the bench changes cmd away from the rising edge.
module cpp_cop_model
  import cpp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire cpp_cop_status_t cmd,
  input wire logic coproc_clock_mode_select,
  output cpp_cop_status_t status,
  output logic mode_bad
);
  // Status lines are registered, so they behave like a real slow part
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      status <= '{1'b1, 1'b1, 1'b0};
      mode_bad <= 1'b0;
    end
    else
    begin
      status <= cmd;
      mode_bad <= mode_bad | !coproc_clock_mode_select;
    end
endmodule

/* tb/cpp_ack_glue_props.sv */
// Port checker for the acknowledge-stretch glue.
// Assumes the bind hands it the glue's own ports, tick included.
module cpp_ack_glue_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic host_operand_ack_n,
  input wire logic host_phase2_start,
  input wire logic ext_freq_tick,
  input wire logic coproc_busy_n,
  input wire logic coproc_error_n,
  input wire logic operand_xfer_request,
  input wire logic stretched_operand_ack_n,
  input wire logic host_busy_n,
  input wire logic host_error_n,
  input wire logic host_operand_xfer_request,
  input wire logic coproc_clk,
  input wire logic coproc_clock_mode_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_ack_gated: assert property (!host_operand_ack_n |-> !stretched_operand_ack_n)
    else $error("stretched ack not low");
  a_busy_pass: assert property (host_busy_n == coproc_busy_n)
    else $error("busy not passed");
  a_error_pass: assert property (host_error_n == coproc_error_n)
    else $error("error not passed");
  a_req_pass: assert property (host_operand_xfer_request == operand_xfer_request)
    else $error("request not passed");
  a_mode_high: assert property (coproc_clock_mode_select)
    else $error("clock mode low");
  a_low_capture: assert property (host_phase2_start && !host_operand_ack_n |=> !stretched_operand_ack_n)
    else $error("low not captured");
  a_min_width: assert property ($fell(stretched_operand_ack_n) |=> !stretched_operand_ack_n)
    else $error("stretched ack too short");
  a_release_strobe: assert property ($rose(stretched_operand_ack_n) |-> $past(host_phase2_start))
    else $error("release without strobe");
  a_div_third: assert property (($rose(coproc_clk) && ext_freq_tick) ##1 ext_freq_tick[*2]
    |=> coproc_clk && !$past(coproc_clk) && !$past(coproc_clk, 2))
    else $error("divider pattern wrong");
  a_div_hold: assert property (!ext_freq_tick |=> $stable(coproc_clk))
    else $error("divider moved without tick");
endmodule
bind cpp_ack_glue cpp_ack_glue_props i_props (.clk_sys(clk_sys), .nrst(nrst),
  .host_operand_ack_n(host_operand_ack_n), .host_phase2_start(host_phase2_start), .ext_freq_tick(ext_freq_tick),
  .coproc_busy_n(coproc_busy_n), .coproc_error_n(coproc_error_n), .operand_xfer_request(operand_xfer_request),
  .stretched_operand_ack_n(stretched_operand_ack_n), .host_busy_n(host_busy_n), .host_error_n(host_error_n),
  .host_operand_xfer_request(host_operand_xfer_request), .coproc_clk(coproc_clk),
  .coproc_clock_mode_select(coproc_clock_mode_select));

/* tb/test_cpp_ack_glue.sv */
// Self-checking bench for the acknowledge-stretch glue.
// Assumes the coprocessor model supplies the status lines.
module test_cpp_ack_glue
  import cpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ack_n = 1'b1;
  logic ph2 = 1'b0;
  logic tick = 1'b1;
  cpp_cop_status_t cmd = '{1'b1, 1'b1, 1'b0};
  cpp_cop_status_t st;
  logic s_ack_n, h_busy_n, h_err_n, h_req, c_clk, mode, mode_bad;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  always #20 clk_sys = ~clk_sys;
  cpp_ack_glue i_dut (.clk_sys(clk_sys), .nrst(nrst), .host_operand_ack_n(ack_n), .host_phase2_start(ph2),
    .ext_freq_tick(tick), .coproc_busy_n(st.busy_n), .coproc_error_n(st.error_n),
    .operand_xfer_request(st.operand_xfer_request), .stretched_operand_ack_n(s_ack_n), .host_busy_n(h_busy_n),
    .host_error_n(h_err_n), .host_operand_xfer_request(h_req), .coproc_clk(c_clk),
    .coproc_clock_mode_select(mode));
  cpp_cop_model i_cop (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd), .coproc_clock_mode_select(mode),
    .status(st), .mode_bad(mode_bad));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic conclude;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    cyc(1);
    check(s_ack_n, 1'b1);
    check(c_clk, 1'b0);
    cyc(3);
    nrst = 1'b1;
    $display("reset test done");
  endtask
  // Two handshakes back to back, then one cut by reset
  task automatic t_walk;
    repeat (2)
    begin
      cyc(1);
      ack_n = 1'b0;
      #1 check(s_ack_n, 1'b0);
      cyc(1);
      ph2 = 1'b1;
      cyc(1);
      ph2 = 1'b0;
      cyc(1);
      ack_n = 1'b1;
      #1 check(s_ack_n, 1'b0);
      cyc(1);
      ph2 = 1'b1;
      cyc(1);
      ph2 = 1'b0;
      check(s_ack_n, 1'b1);
    end
    ack_n = 1'b0;
    ph2 = 1'b1;
    cyc(1);
    ph2 = 1'b0;
    ack_n = 1'b1;
    nrst = 1'b0;
    #1 check(s_ack_n, 1'b1);
    cyc(1);
    nrst = 1'b1;
    $display("walk test done");
  endtask
  task automatic t_pass;
    for (int i = 0; i < 8; i++)
    begin
      cmd = cpp_cop_status_t'(i[2:0]);
      cyc(2);
      check({h_busy_n, h_err_n, h_req}, i[7:0]);
    end
    check({mode, mode_bad}, 8'h02);
    $display("pass test done");
  endtask
  task automatic t_clock;
    n = 0;
    repeat (30)
    begin
      cyc(1);
      n += c_clk;
    end
    check(n[7:0], 8'h0A);
    tick = 1'b0;
    n = c_clk;
    repeat (4)
    begin
      cyc(1);
      check(c_clk, n[0]);
    end
    tick = 1'b1;
    $display("clock test done");
  endtask
  initial
  begin
    #100us;
    miscompares++;
    conclude();
  end
  initial
  begin
    t_reset();
    t_walk();
    t_pass();
    t_clock();
    conclude();
  end
endmodule
